// ===== pkg/lke_map.svh
// Purpose: Offsets, field positions, reset values for legacy keyboard emulation
// Assumes: Offsets are byte offsets from the operational register base
// Notes: Definitions only
`ifndef LKE_MAP_SVH
`define LKE_MAP_SVH
`define LKE_OFS_CONTROL 12'h100
`define LKE_OFS_INPUT 12'h104
`define LKE_OFS_OUTPUT 12'h108
`define LKE_OFS_STATUS 12'h10C
`define LKE_PORT_DATA 16'h0060
`define LKE_PORT_CMD 16'h0064
`define LKE_CMD_GATE_A20 8'hD1
`define LKE_CTRL_RESET 9'h000
`define LKE_CTRL_SW_MASK 9'h13D
`define LKE_CTRL_W1C_MASK 9'h0C0
`define LKE_BIT_OUT_FULL 0
`define LKE_BIT_IN_FULL 1
`define LKE_BIT_CMD_DATA 3
`define LKE_BIT_AUX_FULL 5
`define LKE_BIT_GA20_DATA 1
`define LKE_SYNC_STAGES 2
`endif

// ===== pkg/lke_pkg.sv
// Purpose: Types shared by the legacy keyboard emulation block
// Assumes: Nothing
// Notes: Field order follows the register bit order, MSB first
package lke_pkg;
    typedef struct packed {
        logic gate_a20_level;
        logic mouse_irq_seen;
        logic keyboard_irq_seen;
        logic gate_a20_seq_active;
        logic kbc_irq_forward_en;
        logic output_irq_enable;
        logic char_pend_int_en;
        logic emulation_int_flag;
        logic legacy_emul_on;
    } lke_ctrl_s;
    typedef struct packed {
        logic parity_err;
        logic timeout_err;
        logic aux_out_full;
        logic inhibit_sw;
        logic cmd_data;
        logic sys_flag;
        logic in_full;
        logic out_full;
    } lke_stat_s;
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } lke_io_req_s;
endpackage

// ===== rtl/lke_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is asynchronous to clk
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module lke_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] hold_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= async_in;
            hold_ff <= meta_ff;
        end
    end
    assign sync_out = hold_ff;
endmodule

// ===== rtl/lke_rise.sv
// Purpose: Rising edge detector, pulse decoded combinationally from input and last value
// Assumes: Input already in the clk domain
// Notes: Pulse lasts one cycle
`timescale 1ns/10ps
module lke_rise #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] rise_pulse
);
    logic [WIDTH-1:0] last_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= '0;
        end else begin
            last_ff <= level_in;
        end
    end
    assign rise_pulse = level_in & ~last_ff;
endmodule

// ===== rtl/lke_top.sv
// Purpose: Legacy keyboard and mouse emulation registers and port trapping
// Assumes: Register and I/O requests come from logic on clk
// Notes: Keyboard controller IRQ pins are synchronised before use
//
// Overview of operation
// - Four registers at 100h, 104h, 108h, 10Ch
// - Port 60h read returns output, clears full
// - Port 60h write captures, sets in_full, clears cmd
// - Port 64h read returns status, no effects
// - Port 64h write captures, clears in_full, sets cmd
// - Control bit 8 is A20 level, compared
// - Bit 7 flags MOUSE_IRQ_LINE edge, write one clears
// - Bit 6 flags KEYBOARD_IRQ_LINE edge, write one clears
// - Bit 5 set by D1h, cleared otherwise
// - Bit 4 forwards controller IRQs as emulation interrupt
// - Bit 3 drives KEYBOARD_IRQ_LINE or MOUSE_IRQ_LINE while full
// - Bit 2 interrupts while output buffer empty
// - Bit 1 read-only emulation interrupt condition
// - Bit 0 enables decode, IRQs, emulation interrupts other than forwarded controller IRQs
// - Input register low byte holds written byte
// - Memory status access has no side effects
`timescale 1ns/10ps
`include "lke_map.svh"
module lke_top #(
    parameter int RAW = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Memory register port
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [RAW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack_ff,
    output logic [31:0] reg_rdata_ff,
    // Trapped I/O cycles
    input wire lke_pkg::lke_io_req_s io_in,
    output logic io_ack_ff,
    output logic io_claim_ff,
    output logic [7:0] io_rdata_ff,
    // Keyboard controller IRQ pins
    input wire logic kbc_keyboard_irq_line_pin,
    input wire logic kbc_mouse_irq_line_pin,
    // Interrupt outputs
    output logic keyboard_irq_line_ff,
    output logic mouse_irq_line_ff,
    output logic emul_int_ff
);
    logic [1:0] rst_pipe_ff;
    logic rst_n;
    lke_pkg::lke_ctrl_s ctrl_ff;
    lke_pkg::lke_ctrl_s nxt_ctrl;
    lke_pkg::lke_stat_s stat_ff;
    lke_pkg::lke_stat_s nxt_stat;
    logic [7:0] in_data_ff;
    logic [7:0] out_data_ff;
    logic a20_quiet_ff;
    logic [1:0] kbc_sync;
    logic [1:0] kbc_rise;
    logic port_hit;
    logic rd60;
    logic wr60;
    logic rd64;
    logic wr64;
    logic a20_match;
    logic ei_cond;

    function automatic logic addr_is(input logic [RAW-1:0] a, input logic [11:0] ofs);
        addr_is = (a == ofs[RAW-1:0]);
    endfunction

    function automatic logic port_is(input logic [15:0] a, input logic [15:0] p);
        port_is = (a == p);
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_ff[1];

    lke_sync #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({kbc_mouse_irq_line_pin, kbc_keyboard_irq_line_pin}),
        .sync_out(kbc_sync)
    );

    lke_rise #(.WIDTH(2)) u_rise (
        .clk(clk),
        .rst_n(rst_n),
        .level_in(kbc_sync),
        .rise_pulse(kbc_rise)
    );

    assign port_hit = io_in.req && ctrl_ff.legacy_emul_on &&
        (port_is(io_in.addr, `LKE_PORT_DATA) || port_is(io_in.addr, `LKE_PORT_CMD));
    assign rd60 = port_hit && !io_in.wr && port_is(io_in.addr, `LKE_PORT_DATA);
    assign wr60 = port_hit && io_in.wr && port_is(io_in.addr, `LKE_PORT_DATA);
    assign rd64 = port_hit && !io_in.wr && port_is(io_in.addr, `LKE_PORT_CMD);
    assign wr64 = port_hit && io_in.wr && port_is(io_in.addr, `LKE_PORT_CMD);

    assign a20_match = wr60 && ctrl_ff.gate_a20_seq_active &&
        (io_in.wdata[`LKE_BIT_GA20_DATA] == ctrl_ff.gate_a20_level);

    // Matching A20 data needs no software, so it raises no interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a20_quiet_ff <= 1'b0;
        end else if (wr60 || wr64) begin
            a20_quiet_ff <= a20_match;
        end
    end

    assign ei_cond = (ctrl_ff.kbc_irq_forward_en &&
            (ctrl_ff.keyboard_irq_seen || ctrl_ff.mouse_irq_seen)) ||
        (ctrl_ff.legacy_emul_on && stat_ff.in_full && !a20_quiet_ff) ||
        (ctrl_ff.legacy_emul_on && ctrl_ff.char_pend_int_en && !stat_ff.out_full);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (reg_req && reg_wr && addr_is(reg_addr, `LKE_OFS_CONTROL)) begin
            nxt_ctrl = (ctrl_ff & ~`LKE_CTRL_SW_MASK) |
                (lke_pkg::lke_ctrl_s'(reg_wdata[8:0]) & `LKE_CTRL_SW_MASK);
            nxt_ctrl.mouse_irq_seen = ctrl_ff.mouse_irq_seen & ~reg_wdata[7];
            nxt_ctrl.keyboard_irq_seen = ctrl_ff.keyboard_irq_seen & ~reg_wdata[6];
        end
        if (kbc_rise[1]) begin
            nxt_ctrl.mouse_irq_seen = 1'b1;
        end
        if (kbc_rise[0]) begin
            nxt_ctrl.keyboard_irq_seen = 1'b1;
        end
        if (wr64) begin
            nxt_ctrl.gate_a20_seq_active = (io_in.wdata == `LKE_CMD_GATE_A20);
        end
        nxt_ctrl.emulation_int_flag = ei_cond;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= lke_pkg::lke_ctrl_s'(`LKE_CTRL_RESET);
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // memory writes plain, port effects win
    always_comb begin
        nxt_stat = stat_ff;
        if (reg_req && reg_wr && addr_is(reg_addr, `LKE_OFS_STATUS)) begin
            nxt_stat = lke_pkg::lke_stat_s'(reg_wdata[7:0]);
        end
        if (rd60) begin
            nxt_stat.out_full = 1'b0;
        end
        if (wr60) begin
            nxt_stat.in_full = 1'b1;
            nxt_stat.cmd_data = 1'b0;
        end
        if (wr64) begin
            nxt_stat.in_full = 1'b0;
            nxt_stat.cmd_data = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_data_ff <= 8'h00;
        end else if (wr60 || wr64) begin
            in_data_ff <= io_in.wdata;
        end else if (reg_req && reg_wr && addr_is(reg_addr, `LKE_OFS_INPUT)) begin
            in_data_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data_ff <= 8'h00;
        end else if (reg_req && reg_wr && addr_is(reg_addr, `LKE_OFS_OUTPUT)) begin
            out_data_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ack_ff <= 1'b0;
            reg_rdata_ff <= 32'h0000_0000;
        end else begin
            reg_ack_ff <= reg_req;
            reg_rdata_ff <= 32'h0000_0000;
            if (reg_req && !reg_wr) begin
                if (addr_is(reg_addr, `LKE_OFS_CONTROL)) begin
                    reg_rdata_ff <= {23'h00_0000, ctrl_ff};
                end else if (addr_is(reg_addr, `LKE_OFS_INPUT)) begin
                    reg_rdata_ff <= {24'h00_0000, in_data_ff};
                end else if (addr_is(reg_addr, `LKE_OFS_OUTPUT)) begin
                    reg_rdata_ff <= {24'h00_0000, out_data_ff};
                end else if (addr_is(reg_addr, `LKE_OFS_STATUS)) begin
                    reg_rdata_ff <= {24'h00_0000, stat_ff};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_ack_ff <= 1'b0;
            io_claim_ff <= 1'b0;
            io_rdata_ff <= 8'h00;
        end else begin
            io_ack_ff <= io_in.req;
            io_claim_ff <= port_hit;
            io_rdata_ff <= rd60 ? out_data_ff : (rd64 ? stat_ff : 8'h00);
        end
    end

    // IRQs need enable
    // Lines follow output full; seen bits only hold the emulation interrupt until written one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keyboard_irq_line_ff <= 1'b0;
            mouse_irq_line_ff <= 1'b0;
            emul_int_ff <= 1'b0;
        end else begin
            keyboard_irq_line_ff <= ctrl_ff.legacy_emul_on && ctrl_ff.output_irq_enable &&
                stat_ff.out_full && !stat_ff.aux_out_full;
            mouse_irq_line_ff <= ctrl_ff.legacy_emul_on && ctrl_ff.output_irq_enable &&
                stat_ff.out_full && stat_ff.aux_out_full;
            emul_int_ff <= ei_cond;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd60;
        io_in.req && !io_in.wr && io_in.addr == `LKE_PORT_DATA && ctrl_ff.legacy_emul_on;
    endsequence
    sequence s_wr60;
        io_in.req && io_in.wr && io_in.addr == `LKE_PORT_DATA && ctrl_ff.legacy_emul_on;
    endsequence
    sequence s_wr64;
        io_in.req && io_in.wr && io_in.addr == `LKE_PORT_CMD && ctrl_ff.legacy_emul_on;
    endsequence

    property p_ctrl_read;
        reg_req && !reg_wr && reg_addr == `LKE_OFS_CONTROL |=>
            reg_ack_ff && reg_rdata_ff[8:0] == $past(ctrl_ff) && reg_rdata_ff[31:9] == '0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_rd60;
        s_rd60 |=> io_claim_ff && io_rdata_ff == $past(out_data_ff) && !stat_ff.out_full;
    endproperty
    a_rd60: assert property (p_rd60) else $error("port 60h read wrong");

    property p_wr60;
        s_wr60 |=> stat_ff.in_full && !stat_ff.cmd_data && in_data_ff == $past(io_in.wdata);
    endproperty
    a_wr60: assert property (p_wr60) else $error("port 60h write wrong");

    property p_rd64;
        io_in.req && !io_in.wr && io_in.addr == `LKE_PORT_CMD && ctrl_ff.legacy_emul_on
            && !reg_req && !$past(kbc_rise[0])
            |=> io_rdata_ff == $past(stat_ff) && stat_ff == $past(stat_ff);
    endproperty
    a_rd64: assert property (p_rd64) else $error("port 64h read wrong");

    property p_wr64;
        s_wr64 |=> !stat_ff.in_full && stat_ff.cmd_data && in_data_ff == $past(io_in.wdata);
    endproperty
    a_wr64: assert property (p_wr64) else $error("port 64h write wrong");

    property p_kbd_seen;
        kbc_rise[0] |=> ctrl_ff.keyboard_irq_seen;
    endproperty
    a_kbd_seen: assert property (p_kbd_seen) else $error("keyboard_irq_line edge lost");

    property p_mouse_seen;
        kbc_rise[1] |=> ctrl_ff.mouse_irq_seen;
    endproperty
    a_mouse_seen: assert property (p_mouse_seen) else $error("mouse_irq_line edge lost");

    property p_ga20;
        s_wr64 |=> ctrl_ff.gate_a20_seq_active == ($past(io_in.wdata) == `LKE_CMD_GATE_A20);
    endproperty
    a_ga20: assert property (p_ga20) else $error("gate a20 flag wrong");

    property p_irq_route;
        ctrl_ff.legacy_emul_on && ctrl_ff.output_irq_enable && stat_ff.out_full
            |=> keyboard_irq_line_ff != mouse_irq_line_ff;
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("irq routing wrong");

    property p_disabled;
        !ctrl_ff.legacy_emul_on && io_in.req |=> !io_claim_ff &&
            (stat_ff == $past(stat_ff) || $past(reg_req));
    endproperty
    a_disabled: assert property (p_disabled) else $error("claimed while disabled");

    // A written one must not reach the read-only flag
    property p_ei_ro;
        reg_req && reg_wr && reg_addr == `LKE_OFS_CONTROL && reg_wdata[1] && !ei_cond
            |=> !ctrl_ff.emulation_int_flag;
    endproperty
    a_ei_ro: assert property (p_ei_ro) else $error("emulation flag mismatch");
endmodule

// ===== dv/lke_host_model.sv
// Purpose: Host side issuing trapped keyboard port cycles
// Assumes: Requests change at the falling edge, one-cycle pulse each
// Notes: Address and data are scrambled after each cycle, never left stale
`timescale 1ns/10ps
module lke_host_model (
    // Clock
    input wire logic clk,
    // Cycle to the device
    output lke_pkg::lke_io_req_s io_out,
    // Answer from the device
    input wire logic io_ack,
    input wire logic io_claim,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_out = '0;
    end

    task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                            output logic claim, output logic [7:0] rdata);
        int n;
        n = 0;
        @(negedge clk);
        io_out = {1'b1, wr, addr, wdata};
        @(negedge clk);
        io_out.req = 1'b0;
        while (io_ack !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
        end
        // A missing answer returns unknowns so every later compare fails
        claim = (io_ack === 1'b1) ? io_claim : 1'bx;
        rdata = (io_ack === 1'b1) ? io_rdata : 8'hxx;
        io_out.addr = ~addr;
        io_out.wdata = ~wdata;
    endtask
endmodule

// ===== dv/tb_legacy_keyboard_emulation.sv
// Purpose: Self-checking bench for the legacy keyboard emulation block
// Assumes: Inputs change at the falling edge; random seed fixed at 47
// Notes: Reserved register bits are always written as zero
`timescale 1ns/10ps
`include "lke_map.svh"
module tb_legacy_keyboard_emulation;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_req = 1'b0;
    logic reg_wr = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_ack_ff;
    logic [31:0] reg_rdata_ff;
    lke_pkg::lke_io_req_s io_in;
    logic io_ack_ff;
    logic io_claim_ff;
    logic [7:0] io_rdata_ff;
    logic [1:0] kbc_pins = 2'b00;
    logic kb_irq;
    logic ms_irq;
    logic emul_int;
    int errors = 0;
    int checks_done = 0;
    logic c;
    logic w;
    logic [7:0] b;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] o;
    logic [15:0] a;
    logic [31:0] q;
    logic [7:0] irq_s [4] = '{8'h01, 8'h21, 8'h20, 8'h01};

    always #50 clk = ~clk;

    lke_top #(.RAW(12)) DUT (
        .clk(clk), .reset_n(reset_n),
        .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_ack_ff(reg_ack_ff), .reg_rdata_ff(reg_rdata_ff),
        .io_in(io_in), .io_ack_ff(io_ack_ff), .io_claim_ff(io_claim_ff),
        .io_rdata_ff(io_rdata_ff),
        .kbc_keyboard_irq_line_pin(kbc_pins[0]), .kbc_mouse_irq_line_pin(kbc_pins[1]),
        .keyboard_irq_line_ff(kb_irq), .mouse_irq_line_ff(ms_irq), .emul_int_ff(emul_int)
    );

    lke_host_model u_host (
        .clk(clk), .io_out(io_in), .io_ack(io_ack_ff), .io_claim(io_claim_ff),
        .io_rdata(io_rdata_ff)
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic reg_acc(input logic wr_en, input logic [11:0] ad, input logic [31:0] wd,
                           output logic [31:0] rd_q);
        int n;
        n = 0;
        @(negedge clk);
        reg_req = 1'b1;
        reg_wr = wr_en;
        reg_addr = ad;
        reg_wdata = wd;
        @(negedge clk);
        reg_req = 1'b0;
        while (reg_ack_ff !== 1'b1 && n < 3) begin
            @(negedge clk);
            n++;
        end
        rd_q = (reg_ack_ff === 1'b1) ? reg_rdata_ff : 32'hxxxx_xxxx;
        reg_wdata = ~wd;
    endtask

    task automatic rd(input string nm, input logic [11:0] ad, input logic [31:0] exp);
        logic [31:0] r;
        reg_acc(1'b0, ad, 32'h0000_0000, r);
        check(nm, r, exp);
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
        logic [31:0] r;
        reg_acc(1'b1, ad, wd, r);
    endtask

    // Status after one claimed port cycle, from the port side effects
    function automatic logic [7:0] port_stat(input logic [15:0] ad, input logic wr_en,
                                             input logic [7:0] st);
        if (ad == `LKE_PORT_DATA && !wr_en) return st & 8'hFE;
        if (ad == `LKE_PORT_DATA) return (st | 8'h02) & 8'hF7;
        if (wr_en) return (st & 8'hFD) | 8'h08;
        return st;
    endfunction

    initial begin
        #2000000;
        errors = errors + 1;
        test_done();
    end

    initial begin
        void'($urandom(47));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        wr(12'h200, 32'h0000_00FF);
        for (int i = 0; i < 5; i++) begin
            rd("reset_reg", 12'h100 + 12'(i * 4), 32'h0000_0000);
        end
        for (int i = 1; i < 4; i++) begin
            wr(12'h100 + 12'(i * 4), 32'h0000_0011 * 32'(i));
        end
        for (int i = 1; i < 4; i++) begin
            rd("map", 12'h100 + 12'(i * 4), 32'h0000_0011 * 32'(i));
        end
        // Emulation off: nothing claimed, nothing changed
        u_host.io_cycle(1'b1, `LKE_PORT_DATA, 8'h3C, c, b);
        check("claim_off", c, 1'b0);
        rd("input_off", 12'h104, 32'h0000_0011);
        rd("status_off", 12'h10C, 32'h0000_0033);
        wr(12'h100, 32'h0000_0002);
        rd("ro_flag", 12'h100, 32'h0000_0000);
        wr(12'h100, 32'h0000_0001);
        // Other ports stay unclaimed even with emulation on
        u_host.io_cycle(1'b0, 16'h0061, 8'h00, c, b);
        check("claim_other", c, 1'b0);
        check("rdata_other", b, 8'h00);
        for (int i = 0; i < 12; i++) begin
            w = (i < 2) ? 1'b1 : 1'($urandom);
            a = (i < 2 || $urandom % 2) ? `LKE_PORT_CMD : `LKE_PORT_DATA;
            d = (i == 0) ? `LKE_CMD_GATE_A20 : 8'($urandom);
            s = 8'($urandom);
            o = 8'($urandom);
            wr(12'h108, {24'h00_0000, o});
            wr(12'h10C, {24'h00_0000, s});
            rd("status_mem", 12'h10C, {24'h00_0000, s});
            u_host.io_cycle(w, a, d, c, b);
            check("claim", c, 1'b1);
            check("io_rdata", b, w ? 8'h00 : (a == `LKE_PORT_DATA ? o : s));
            rd("status_port", 12'h10C, {24'h00_0000, port_stat(a, w, s)});
            if (w) begin
                rd("input_port", 12'h104, {24'h00_0000, d});
            end
            if (w && a == `LKE_PORT_CMD) begin
                reg_acc(1'b0, 12'h100, 32'h0000_0000, q);
                check("gate_seq", q[5], d == `LKE_CMD_GATE_A20);
            end
        end
        // Routing of the output-full interrupt, last pass with emulation off
        for (int k = 0; k < 4; k++) begin
            wr(12'h100, (k == 3) ? 32'h0000_0008 : 32'h0000_0009);
            wr(12'h10C, {24'h00_0000, irq_s[k]});
            repeat (3) @(negedge clk);
            check("kb_irq", kb_irq, irq_s[k][0] & ~irq_s[k][5] & (k < 3));
            check("ms_irq", ms_irq, irq_s[k][0] & irq_s[k][5] & (k < 3));
        end
        wr(12'h10C, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            wr(12'h100, 32'h0000_0010);
            kbc_pins = 2'(1 << k);
            repeat (5) @(negedge clk);
            check("ext_int", emul_int, 1'b1);
            wr(12'h100, 32'h0000_0010);
            rd("seen", 12'h100, 32'h0000_0012 | 32'(64 << k));
            wr(12'h100, 32'h0000_0010 | 32'(64 << k));
            kbc_pins = 2'b00;
            rd("seen_clr", 12'h100, 32'h0000_0010);
        end
        wr(12'h100, 32'h0000_0005);
        repeat (3) @(negedge clk);
        check("cp_int", emul_int, 1'b1);
        rd("cp_flag", 12'h100, 32'h0000_0007);
        wr(12'h10C, 32'h0000_0001);
        repeat (3) @(negedge clk);
        check("cp_quiet", emul_int, 1'b0);
        // Gate level 1: data bit 1 of 0 differs and interrupts, 1 matches
        wr(12'h100, 32'h0000_0101);
        for (int k = 0; k < 2; k++) begin
            u_host.io_cycle(1'b1, `LKE_PORT_CMD, `LKE_CMD_GATE_A20, c, b);
            u_host.io_cycle(1'b1, `LKE_PORT_DATA, 8'(k * 2), c, b);
            repeat (3) @(negedge clk);
            check("a20_int", emul_int, k == 0);
            rd("a20_stat", 12'h10C, 32'h0000_0003);
            wr(12'h10C, 32'h0000_0001);
        end
        test_done();
    end
endmodule
